// *** epi_pkg.sv ***
// Package for the external pin interrupt unit: register map, field layout,
// reset values, sense modes and vector addresses. Used by every design file.
package epi_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_CHANGE_MASK_LOW  = 8'h23;
    localparam logic [7:0] ADDR_MCU_CONTROL      = 8'h35;
    localparam logic [7:0] ADDR_IRQ_MASK         = 8'h3b;
    localparam logic [7:0] ADDR_IRQ_FLAGS        = 8'h3a;
    localparam logic [7:0] ADDR_CHANGE_MASK_HIGH = 8'h22;
    localparam logic [7:0] ADDR_GLOBAL_ENABLE    = 8'h3f;

    // Reset values
    localparam logic [7:0] RST_CHANGE_MASK_LOW  = 8'hc8;
    localparam logic [7:0] RST_MCU_CONTROL      = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK         = 8'h00;
    localparam logic [7:0] RST_CHANGE_MASK_HIGH = 8'h00;

    // Field positions and change input count
    localparam int BIT_EXT_B        = 7;
    localparam int BIT_EXT_A        = 6;
    localparam int BIT_GROUP_A      = 5;
    localparam int BIT_GROUP_B      = 4;
    localparam int BIT_GLOBAL       = 7;
    localparam int SENSE_LSB        = 0;
    localparam int CHANGE_INPUTS    = 16;

    // Masks of implemented bits
    localparam logic [7:0] IRQ_MASK_USED  = 8'hf0;
    localparam logic [7:0] IRQ_FLAGS_USED = 8'he0;

    // Vector addresses
    localparam logic [15:0] VEC_EXT_A  = 16'h0001;
    localparam logic [15:0] VEC_CHANGE = 16'h0002;
    localparam logic [15:0] VEC_EXT_B  = 16'h000d;
    localparam logic [15:0] VEC_NONE   = 16'h0000;

    typedef enum logic [1:0] {
        SENSE_LOW    = 2'b00,
        SENSE_CHANGE = 2'b01,
        SENSE_FALL   = 2'b10,
        SENSE_RISE   = 2'b11
    } epi_sense_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } epi_bus_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] vector;
    } epi_req_type;

endpackage : epi_pkg

// *** epi_edge_detect.sv ***
// Per-pin synchroniser and sense decoder for one external request pin.
// Assumes pin is asynchronous to core_clk_in; low level is passed unclocked.
`timescale 1ns/1ps
module epi_edge_detect
(
    // Clock and reset
    input  wire logic               core_clk_in,
    input  wire logic               rst_b_in,
    // Pin and mode
    input  wire logic               pin_in,
    input  wire epi_pkg::epi_sense_type sense_in,
    // Results
    output logic                    edge_hit_out,
    output logic                    low_level_out
);
    logic sync_first;
    logic sync_second;
    logic prev_sample;

    // Two stages before the edge logic looks at the pin
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sync_first  <= 1'b1;
            sync_second <= 1'b1;
            prev_sample <= 1'b1;
        end
        else
        begin
            sync_first  <= pin_in;
            sync_second <= sync_first;
            prev_sample <= sync_second;
        end
    end

    // Edge modes need the clock; pulses over one period always pass
    always_comb
    begin
        case (sense_in)
            epi_pkg::SENSE_CHANGE: edge_hit_out = sync_second ^ prev_sample;
            epi_pkg::SENSE_FALL:   edge_hit_out = prev_sample & ~sync_second;
            epi_pkg::SENSE_RISE:   edge_hit_out = ~prev_sample & sync_second;
            default:               edge_hit_out = 1'b0;
        endcase
    end

    // Asynchronous so it works with the clock stopped
    assign low_level_out = (sense_in == epi_pkg::SENSE_LOW) & ~pin_in;

endmodule : epi_edge_detect

// *** epi_unit.sv ***
// External pin interrupt unit: two request pins, sixteen change inputs,
// mask and flag registers, request and wake outputs.
// Assumes a plain register port on core_clk_in and a core that acks vectors.
`timescale 1ns/1ps
module epi_unit
#(
    parameter int N_CHANGE = epi_pkg::CHANGE_INPUTS
)
(
    // Clock and reset
    input  wire logic                core_clk_in,
    input  wire logic                rst_b_in,
    // Register port
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic [7:0]          reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic [7:0]               reg_rdata_out,
    // Pins
    input  wire logic                ext_irq_pin_a_in,
    input  wire logic                ext_irq_pin_b_in,
    input  wire logic [N_CHANGE-1:0] change_input_in,
    // Core side
    input  wire logic                startup_done_in,
    input  wire logic                vector_ack_in,
    output logic                     irq_req_out,
    output logic [15:0]              irq_vector_out,
    output logic                     wake_out
);
    epi_pkg::epi_bus_type bus;
    epi_pkg::epi_req_type next_req;
    epi_pkg::epi_req_type req;
    epi_pkg::epi_sense_type sense;

    logic [7:0]          change_mask_low;
    logic [7:0]          change_mask_high;
    logic [7:0]          mcu_control;
    logic [7:0]          irq_mask;
    logic                global_enable;
    logic                ext_flag_a;
    logic                ext_flag_b;
    logic                change_flag;
    logic [N_CHANGE-1:0] change_sync_first;
    logic [N_CHANGE-1:0] change_sync;
    logic [N_CHANGE-1:0] change_prev;
    logic [N_CHANGE-1:0] change_enabled;
    logic [N_CHANGE-1:0] change_async;
    logic [N_CHANGE-1:0] change_ref;
    logic                change_hit;
    logic                hit_a;
    logic                hit_b;
    logic                low_a;
    logic                low_b;
    logic                level_mode;
    logic                level_a_live;
    logic                level_b_live;
    logic                clr_a;
    logic                clr_b;
    logic                clr_change;
    logic                flag_wr;

    assign bus   = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};
    assign sense = epi_pkg::epi_sense_type'(mcu_control[epi_pkg::SENSE_LSB +: 2]);
    assign level_mode = (sense == epi_pkg::SENSE_LOW);

    // Pin detectors share one sense field
    epi_edge_detect u_det_a
    (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .pin_in        (ext_irq_pin_a_in),
        .sense_in      (sense),
        .edge_hit_out  (hit_a),
        .low_level_out (low_a)
    );

    epi_edge_detect u_det_b
    (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .pin_in        (ext_irq_pin_b_in),
        .sense_in      (sense),
        .edge_hit_out  (hit_b),
        .low_level_out (low_b)
    );

    // Group enables per input
    generate
        for (genvar i = 0; i < N_CHANGE; i++)
        begin : g_change
            if (i < 8)
            begin : g_low
                assign change_enabled[i] = change_mask_low[i] & irq_mask[epi_pkg::BIT_GROUP_A];
            end
            else if (i < 12)
            begin : g_mid
                assign change_enabled[i] = change_mask_high[i-8] & irq_mask[epi_pkg::BIT_GROUP_B];
            end
            else
            begin : g_high
                assign change_enabled[i] = change_mask_high[i-8] & irq_mask[epi_pkg::BIT_GROUP_A];
            end
        end
    endgenerate

    // Change inputs synchronised for the flag path
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            change_sync_first <= '0;
            change_sync       <= '0;
            change_prev       <= '0;
        end
        else
        begin
            change_sync_first <= change_input_in;
            change_sync       <= change_sync_first;
            change_prev       <= change_sync;
        end
    end

    assign change_hit = |((change_sync ^ change_prev) & change_enabled);

    // Unclocked compare against the last sample; wakes with the clock stopped
    assign change_ref   = change_sync;
    assign change_async = (change_input_in ^ change_ref) & change_enabled;

    // Register writes
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            change_mask_low  <= epi_pkg::RST_CHANGE_MASK_LOW;
            change_mask_high <= epi_pkg::RST_CHANGE_MASK_HIGH;
            mcu_control      <= epi_pkg::RST_MCU_CONTROL;
            irq_mask         <= epi_pkg::RST_IRQ_MASK;
            global_enable    <= 1'b0;
        end
        else if (bus.wr)
        begin
            if (bus.addr == epi_pkg::ADDR_CHANGE_MASK_LOW)
            begin
                change_mask_low <= bus.wdata;
            end
            else if (bus.addr == epi_pkg::ADDR_CHANGE_MASK_HIGH)
            begin
                change_mask_high <= bus.wdata;
            end
            else if (bus.addr == epi_pkg::ADDR_MCU_CONTROL)
            begin
                mcu_control <= bus.wdata;
            end
            else if (bus.addr == epi_pkg::ADDR_IRQ_MASK)
            begin
                irq_mask <= bus.wdata & epi_pkg::IRQ_MASK_USED;
            end
            else if (bus.addr == epi_pkg::ADDR_GLOBAL_ENABLE)
            begin
                global_enable <= bus.wdata[epi_pkg::BIT_GLOBAL];
            end
        end
    end

    // Flag clears: write one or vector entry
    assign flag_wr    = bus.wr & (bus.addr == epi_pkg::ADDR_IRQ_FLAGS);
    assign clr_a      = (flag_wr & bus.wdata[epi_pkg::BIT_EXT_A])
                        | (vector_ack_in & req.valid & (req.vector == epi_pkg::VEC_EXT_A));
    assign clr_b      = (flag_wr & bus.wdata[epi_pkg::BIT_EXT_B])
                        | (vector_ack_in & req.valid & (req.vector == epi_pkg::VEC_EXT_B));
    assign clr_change = (flag_wr & bus.wdata[epi_pkg::BIT_GROUP_A])
                        | (vector_ack_in & req.valid & (req.vector == epi_pkg::VEC_CHANGE));

    // Set wins over clear
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ext_flag_a <= 1'b0;
            ext_flag_b <= 1'b0;
        end
        else if (level_mode)
        begin
            ext_flag_a <= 1'b0;
            ext_flag_b <= 1'b0;
        end
        else
        begin
            ext_flag_a <= hit_a | (ext_flag_a & ~clr_a);
            ext_flag_b <= hit_b | (ext_flag_b & ~clr_b);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            change_flag <= 1'b0;
        end
        else
        begin
            change_flag <= change_hit | (change_flag & ~clr_change);
        end
    end

    // Level requests only count once start-up is done
    assign level_a_live = low_a & startup_done_in;
    assign level_b_live = low_b & startup_done_in;

    // Priority follows vector order
    always_comb
    begin
        next_req = '{valid: 1'b0, vector: epi_pkg::VEC_NONE};
        if (global_enable)
        begin
            if (irq_mask[epi_pkg::BIT_EXT_A] & (ext_flag_a | level_a_live))
            begin
                next_req = '{valid: 1'b1, vector: epi_pkg::VEC_EXT_A};
            end
            else if (change_flag & (irq_mask[epi_pkg::BIT_GROUP_A] | irq_mask[epi_pkg::BIT_GROUP_B]))
            begin
                next_req = '{valid: 1'b1, vector: epi_pkg::VEC_CHANGE};
            end
            else if (irq_mask[epi_pkg::BIT_EXT_B] & (ext_flag_b | level_b_live))
            begin
                next_req = '{valid: 1'b1, vector: epi_pkg::VEC_EXT_B};
            end
        end
    end

    // Request registered; dropped the cycle after an ack
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            req <= '{valid: 1'b0, vector: epi_pkg::VEC_NONE};
        end
        else if (vector_ack_in & req.valid)
        begin
            req <= '{valid: 1'b0, vector: epi_pkg::VEC_NONE};
        end
        else
        begin
            req <= next_req;
        end
    end

    assign irq_req_out    = req.valid;
    assign irq_vector_out = req.vector;

    // Wake runs without the clock; a low level wakes only while it is still on pin a
    assign wake_out = (low_a & irq_mask[epi_pkg::BIT_EXT_A]) | (|change_async);

    // Register reads, data one cycle later
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            reg_rdata_out <= 8'h00;
        end
        else if (bus.rd)
        begin
            if (bus.addr == epi_pkg::ADDR_CHANGE_MASK_LOW)
            begin
                reg_rdata_out <= change_mask_low;
            end
            else if (bus.addr == epi_pkg::ADDR_CHANGE_MASK_HIGH)
            begin
                reg_rdata_out <= change_mask_high;
            end
            else if (bus.addr == epi_pkg::ADDR_MCU_CONTROL)
            begin
                reg_rdata_out <= mcu_control;
            end
            else if (bus.addr == epi_pkg::ADDR_IRQ_MASK)
            begin
                reg_rdata_out <= irq_mask & epi_pkg::IRQ_MASK_USED;
            end
            else if (bus.addr == epi_pkg::ADDR_IRQ_FLAGS)
            begin
                reg_rdata_out <= {ext_flag_b, ext_flag_a, change_flag, 5'h00} & epi_pkg::IRQ_FLAGS_USED;
            end
            else if (bus.addr == epi_pkg::ADDR_GLOBAL_ENABLE)
            begin
                reg_rdata_out <= {global_enable, 7'h00};
            end
            else
            begin
                reg_rdata_out <= 8'h00;
            end
        end
        else
        begin
            reg_rdata_out <= 8'h00;
        end
    end

    // Assertions
    a_level_clears_flags : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        $past(level_mode) |-> (!ext_flag_a && !ext_flag_b))
        else $error("pin flag set in level mode");

    a_global_gates_req : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        irq_req_out |-> $past(global_enable))
        else $error("request without global enable");

    a_fall_sets_flag : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (sense == epi_pkg::SENSE_FALL && $past(sense) == epi_pkg::SENSE_FALL && hit_a) |=> ext_flag_a)
        else $error("falling edge missed");

    a_flag_set_wins : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (!level_mode && hit_b && clr_b) |=> ext_flag_b)
        else $error("clear beat set on pin b");

    a_write_one_clr : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (flag_wr && bus.wdata[epi_pkg::BIT_GROUP_A] && !change_hit) |=> !change_flag)
        else $error("change flag not cleared");

    a_vector_a_code : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (global_enable && irq_mask[epi_pkg::BIT_EXT_A] && ext_flag_a && !(vector_ack_in && req.valid))
        |=> (irq_req_out && irq_vector_out == 16'h0001))
        else $error("pin a vector wrong");

    a_reserved_zero : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (bus.rd && bus.addr == epi_pkg::ADDR_IRQ_FLAGS) |=> (reg_rdata_out[4:0] == 5'h00))
        else $error("reserved flag bits nonzero");

    a_group_b_gate : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        !irq_mask[epi_pkg::BIT_GROUP_B] |-> (change_enabled[11:8] == 4'h0))
        else $error("inputs 11..8 enabled without group");

    a_change_edge : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (change_hit && !clr_change) |=> change_flag ##1 (change_flag || $past(clr_change)))
        else $error("change flag lost");

endmodule : epi_unit

// *** epi_pin_model.sv ***
// Board-side model of the request pins and the sixteen change inputs.
// Assumes the bench calls its tasks; every level change lands just after a clock edge.
`timescale 1ns/1ps
module epi_pin_model
(
    // Clock
    input  wire logic        clk_in,
    // Pins
    output logic             pin_a_out,
    output logic             pin_b_out,
    output logic [15:0]      change_out
);
    // Pins rest high, as with a pull-up; change inputs rest low
    initial
    begin
        pin_a_out  = 1'b1;
        pin_b_out  = 1'b1;
        change_out = 16'h0000;
    end

    // Same driver whether the pin acts as input or output
    // Each level is held many clocks, never a sub-clock pulse
    // A low level is kept until the bench releases it
    task automatic drive_a(input logic v);
        @(posedge clk_in);
        pin_a_out <= v;
    endtask : drive_a

    task automatic drive_b(input logic v);
        @(posedge clk_in);
        pin_b_out <= v;
    endtask : drive_b

    task automatic toggle_change(input int idx);
        @(posedge clk_in);
        change_out[idx] <= ~change_out[idx];
    endtask : toggle_change
endmodule : epi_pin_model

// *** testbench.sv ***
// Self-checking bench for the external pin interrupt unit.
// Assumes the register port answers one cycle after a read strobe.
`timescale 1ns/1ps
module testbench;
    logic        core_clk_in;
    logic        rst_b_in;
    logic [7:0]  reg_addr_in;
    logic [7:0]  reg_wdata_in;
    logic        reg_wr_in;
    logic        reg_rd_in;
    logic [7:0]  reg_rdata_out;
    logic        pin_a;
    logic        pin_b;
    logic [15:0] change;
    logic        startup_done_in;
    logic        vector_ack_in;
    logic        irq_req_out;
    logic [15:0] irq_vector_out;
    logic        wake_out;
    int          mismatches;
    int          total_checks;

    epi_unit i_epi_unit (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .ext_irq_pin_a_in(pin_a), .ext_irq_pin_b_in(pin_b),
        .change_input_in(change), .startup_done_in(startup_done_in), .vector_ack_in(vector_ack_in),
        .irq_req_out(irq_req_out), .irq_vector_out(irq_vector_out), .wake_out(wake_out));

    epi_pin_model i_epi_pin_model (.clk_in(core_clk_in), .pin_a_out(pin_a), .pin_b_out(pin_b),
        .change_out(change));

    initial
    begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check_reg

    task automatic check_req(input logic exp, input logic [15:0] vec);
        total_checks++;
        if (irq_req_out !== exp || (exp === 1'b1 && irq_vector_out !== vec))
        begin
            mismatches++;
            $display("unexpected request: expected %b/%h seen %b/%h", exp, vec, irq_req_out, irq_vector_out);
        end
    endtask : check_req

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= addr;
        reg_wdata_in <= data;
        @(posedge core_clk_in);
        reg_wr_in    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= addr;
        @(posedge core_clk_in);
        reg_rd_in   <= 1'b0;
        #1;
        data = reg_rdata_out;
    endtask : reg_read

    task automatic read_check(input string what, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        reg_read(addr, d);
        check_reg(what, exp, d);
    endtask : read_check

    // Expect a request within a bounded wait, then the flag, ack and flag cleared
    task automatic expect_irq(input logic exp, input logic [15:0] vec, input logic [7:0] flag);
        int n;
        n = 0;
        if (exp)
        begin
            while (irq_req_out !== 1'b1 && n < 12)
            begin
                @(posedge core_clk_in);
                #1;
                n++;
            end
            check_req(1'b1, vec);
            read_check("flags pending", epi_pkg::ADDR_IRQ_FLAGS, flag);
            @(posedge core_clk_in);
            vector_ack_in <= 1'b1;
            @(posedge core_clk_in);
            vector_ack_in <= 1'b0;
            #1;
            check_req(1'b0, vec);
        end
        else
            repeat (10) @(posedge core_clk_in);
        #1;
        check_req(1'b0, vec);
        read_check("flags after", epi_pkg::ADDR_IRQ_FLAGS, 8'h00);
    endtask : expect_irq

    typedef struct { logic [1:0] mode; logic from_lvl; logic to_lvl; logic fire; } epi_edge_case_type;
    typedef struct { int idx; logic [7:0] low; logic [7:0] high; logic [7:0] grp; logic fire; } epi_chg_case_type;
    epi_edge_case_type edge_tab [6] = '{'{2'b01, 1, 0, 1}, '{2'b01, 0, 1, 1}, '{2'b10, 1, 0, 1},
        '{2'b10, 0, 1, 0}, '{2'b11, 0, 1, 1}, '{2'b11, 1, 0, 0}};
    epi_chg_case_type chg_tab [6] = '{'{0, 8'h01, 8'h00, 8'h20, 1}, '{7, 8'h80, 8'h00, 8'h10, 0},
        '{9, 8'h00, 8'h02, 8'h10, 1}, '{9, 8'h00, 8'h02, 8'h20, 0},
        '{14, 8'h00, 8'h40, 8'h20, 1}, '{14, 8'h00, 8'h40, 8'h10, 0}};

    initial
    begin
        mismatches = 0;
        total_checks = 0;
        rst_b_in = 1'b0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        startup_done_in = 1'b1;
        vector_ack_in = 1'b0;
        repeat (3) @(posedge core_clk_in);
        rst_b_in <= 1'b1;

        read_check("change mask low", epi_pkg::ADDR_CHANGE_MASK_LOW, 8'hc8);
        read_check("mcu control", epi_pkg::ADDR_MCU_CONTROL, 8'h00);
        read_check("change mask high", epi_pkg::ADDR_CHANGE_MASK_HIGH, 8'h00);
        read_check("irq mask", epi_pkg::ADDR_IRQ_MASK, 8'h00);
        read_check("unmapped", 8'h10, 8'h00);
        reg_write(epi_pkg::ADDR_IRQ_MASK, 8'hff);
        read_check("mask reserved", epi_pkg::ADDR_IRQ_MASK, 8'hf0);
        reg_write(epi_pkg::ADDR_IRQ_MASK, 8'h00);
        $display("test registers done");

        // Flag sets without global enable, no request; cleared by writing one
        reg_write(epi_pkg::ADDR_MCU_CONTROL, 8'h02);
        reg_write(epi_pkg::ADDR_IRQ_MASK, 8'h40);
        i_epi_pin_model.drive_a(1'b0);
        repeat (8) @(posedge core_clk_in);
        #1;
        check_req(1'b0, epi_pkg::VEC_NONE);
        read_check("flag a set", epi_pkg::ADDR_IRQ_FLAGS, 8'h40);
        reg_write(epi_pkg::ADDR_IRQ_FLAGS, 8'h40);
        read_check("flag a cleared", epi_pkg::ADDR_IRQ_FLAGS, 8'h00);
        i_epi_pin_model.drive_a(1'b1);
        reg_write(epi_pkg::ADDR_GLOBAL_ENABLE, 8'h80);
        $display("test global enable done");

        foreach (edge_tab[i])
        begin
            reg_write(epi_pkg::ADDR_IRQ_MASK, 8'h00);
            reg_write(epi_pkg::ADDR_MCU_CONTROL, {6'h00, edge_tab[i].mode});
            i_epi_pin_model.drive_a(edge_tab[i].from_lvl);
            repeat (6) @(posedge core_clk_in);
            reg_write(epi_pkg::ADDR_IRQ_FLAGS, 8'he0);
            reg_write(epi_pkg::ADDR_IRQ_MASK, 8'h40);
            i_epi_pin_model.drive_a(edge_tab[i].to_lvl);
            expect_irq(edge_tab[i].fire, epi_pkg::VEC_EXT_A, 8'h40);
        end
        $display("test sense modes done");

        // Pin b on the shared field, own mask bit and vector
        reg_write(epi_pkg::ADDR_IRQ_MASK, 8'h80);
        reg_write(epi_pkg::ADDR_MCU_CONTROL, 8'h02);
        i_epi_pin_model.drive_b(1'b0);
        expect_irq(1'b1, epi_pkg::VEC_EXT_B, 8'h80);
        i_epi_pin_model.drive_b(1'b1);
        // Write-one clear lands in the same cycle as a falling edge on pin b
        reg_write(epi_pkg::ADDR_IRQ_MASK, 8'h00);
        i_epi_pin_model.drive_b(1'b0);
        @(posedge core_clk_in);
        reg_write(epi_pkg::ADDR_IRQ_FLAGS, 8'h80);
        read_check("set beats clear", epi_pkg::ADDR_IRQ_FLAGS, 8'h80);
        i_epi_pin_model.drive_b(1'b1);
        $display("test pin b done");

        // Level mode: request persists while low, flag stays clear
        i_epi_pin_model.drive_a(1'b1);
        reg_write(epi_pkg::ADDR_IRQ_MASK, 8'h00);
        reg_write(epi_pkg::ADDR_MCU_CONTROL, 8'h00);
        reg_write(epi_pkg::ADDR_IRQ_MASK, 8'h40);
        i_epi_pin_model.drive_a(1'b0);
        repeat (6) @(posedge core_clk_in);
        #1;
        check_req(1'b1, epi_pkg::VEC_EXT_A);
        read_check("level flag", epi_pkg::ADDR_IRQ_FLAGS, 8'h00);
        @(posedge core_clk_in);
        vector_ack_in <= 1'b1;
        @(posedge core_clk_in);
        vector_ack_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        #1;
        check_req(1'b1, epi_pkg::VEC_EXT_A);
        startup_done_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        #1;
        check_reg("wake", 8'h01, {7'h00, wake_out});
        check_req(1'b0, epi_pkg::VEC_NONE);
        i_epi_pin_model.drive_a(1'b1);
        startup_done_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        #1;
        check_req(1'b0, epi_pkg::VEC_NONE);
        $display("test level mode done");

        reg_write(epi_pkg::ADDR_MCU_CONTROL, 8'h02);
        foreach (chg_tab[i])
        begin
            reg_write(epi_pkg::ADDR_IRQ_MASK, 8'h00);
            reg_write(epi_pkg::ADDR_CHANGE_MASK_LOW, chg_tab[i].low);
            reg_write(epi_pkg::ADDR_CHANGE_MASK_HIGH, chg_tab[i].high);
            reg_write(epi_pkg::ADDR_IRQ_FLAGS, 8'he0);
            reg_write(epi_pkg::ADDR_IRQ_MASK, chg_tab[i].grp);
            i_epi_pin_model.toggle_change(chg_tab[i].idx);
            expect_irq(chg_tab[i].fire, epi_pkg::VEC_CHANGE, 8'h20);
        end
        $display("test change inputs done");
        test_done();
    end

    initial
    begin
        #200000;
        mismatches++;
        test_done();
    end
endmodule : testbench
